// ===== rals_pkg.sv
// Shared constants for the receive alarm and loop-code status block
`default_nettype none
package rals_pkg;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int unsigned RALS_CLK_HZ = 100_000_000; // System clock rate
  localparam int unsigned RALS_HOLD_S = 5; // Code persistence time in seconds
  // Cycles a code must stay present; held asserts one cycle past this
  localparam logic [31:0] RALS_HOLD_CYC = 32'(RALS_HOLD_S * RALS_CLK_HZ);

  // ---------------------------------------------------------------
  // Register map (byte addresses)
  // ---------------------------------------------------------------
  localparam int RALS_AW = 8; // Register address width
  localparam logic [7:0] RALS_OFF_STATUS = 8'h00; // Live alarm status, RO
  localparam logic [7:0] RALS_OFF_IRQ_EN = 8'h04; // Interrupt enables, RW
  localparam logic [7:0] RALS_OFF_MODE = 8'h08; // Loop-code mode bits, RW
  localparam logic [7:0] RALS_OFF_IRQ_STS = 8'h0c; // Sticky events, W1C

  // Field positions; lock to loop-code shared by status, enable and event registers
  localparam int RALS_BIT_LOCK = 0; // Test pattern lock
  localparam int RALS_BIT_LOS = 1; // Receive signal lost
  localparam int RALS_BIT_AIS = 2; // All-ones alarm
  localparam int RALS_BIT_LC = 3; // Loop-code flag
  localparam int RALS_BIT_MODE_LO = 0; // Mode low bit
  localparam int RALS_BIT_MODE_HI = 1; // Mode high bit

  // Reset values
  localparam logic [3:0] RALS_RST_IRQ_EN = 4'h0;
  localparam logic [1:0] RALS_RST_MODE = 2'h0;

  // AXI responses
  localparam logic [1:0] RALS_RESP_OKAY = 2'h0;
  localparam logic [1:0] RALS_RESP_SLVERR = 2'h2;

  // Mode codes
  localparam logic [1:0] RALS_MODE_OFF = 2'h0;
  localparam logic [1:0] RALS_MODE_AUTO = 2'h3;

  // Loop-code controller states, Gray along off-manual-arm-loop
  typedef enum logic [1:0] {
    RALS_ST_OFF = 2'h0,
    RALS_ST_MANUAL = 2'h1,
    RALS_ST_AUTO_UP = 2'h3,
    RALS_ST_AUTO_LOOP = 2'h2
  } rals_st_t;

endpackage
`default_nettype wire

// ===== rals_sync.sv
// Two-flop synchroniser for a vector of independent level inputs
`default_nettype none
module rals_sync #(
  parameter int W = 5
) (
  input wire logic i_clk_sys,
  input wire logic i_nrst,
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);
  import rals_pkg::*;

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [W-1:0] s1; // First stage, read only by second stage
    logic [W-1:0] s2; // Second stage, safe to use
  } rals_sync_state_t;

  rals_sync_state_t s_q;
  rals_sync_state_t s_d;

  // Next state: shift one stage per clock
  always_comb
  begin
    s_d = s_q;
    s_d.s1 = i_async;
    s_d.s2 = s_q.s1;
  end

  // Registers with synchronous reset
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_nrst)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign o_sync = s_q.s2;

endmodule
`default_nettype wire

// ===== rals_persist.sv
// Persistence timer: flags a level that has stayed high past a hold time
`default_nettype none
module rals_persist (
  input wire logic i_clk_sys,
  input wire logic i_nrst,
  input wire logic [31:0] i_hold_cyc,
  input wire logic i_present,
  output logic o_held
);
  import rals_pkg::*;

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [31:0] cnt; // Cycles the level has been present
    logic held; // Level present longer than hold time
  } rals_persist_state_t;

  rals_persist_state_t s_q;
  rals_persist_state_t s_d;

  // Count while present; any gap restarts, so held drops at once
  always_comb
  begin
    s_d = s_q;
    if (!i_present)
    begin
      s_d.cnt = '0;
      s_d.held = 1'b0;
    end
    else if (s_q.cnt == i_hold_cyc)
    begin
      // Saturate: strictly longer than the hold time
      s_d.held = 1'b1;
    end
    else
    begin
      s_d.cnt = s_q.cnt + 32'h1;
    end
  end

  // Registers with synchronous reset
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_nrst)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign o_held = s_q.held;

endmodule
`default_nettype wire

// ===== rals_top.sv
// Receive alarm status and network loop-code detection with AXI4-Lite access
`default_nettype none
module rals_top #(
  parameter logic [31:0] HOLD_CYC = rals_pkg::RALS_HOLD_CYC // Shorten for simulation
) (
  input wire logic i_clk_sys,
  input wire logic i_nrst,
  // Detector levels from receive path (other domain)
  input wire logic i_loop_up_seen,
  input wire logic i_loop_down_seen,
  input wire logic i_all_ones_det,
  input wire logic i_signal_lost_det,
  input wire logic i_pattern_lock_det,
  // Block outputs
  output logic o_loop_code_flag,
  output logic o_remote_loopback,
  output logic o_irq,
  // AXI4-Lite slave
  input wire logic [rals_pkg::RALS_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [rals_pkg::RALS_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  import rals_pkg::*;

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    rals_st_t st; // Loop-code controller state
    logic flag; // Loop-code flag
    logic rlb; // Remote loopback active
    logic [3:0] prev; // Status seen last cycle, for change detect
    logic [3:0] sts; // Sticky event bits
    logic [3:0] en; // Interrupt enables (mask)
    logic [1:0] mode; // Loop-code mode bits
    logic aw_got; // Write address held
    logic [RALS_AW-1:0] awaddr; // Held write address
    logic w_got; // Write data held
    logic [7:0] wdata; // Held write data, low lane
    logic wlane; // Held low-lane strobe
    logic bvalid; // Write response pending
    logic [1:0] bresp; // Write response code
    logic rvalid; // Read response pending
    logic [1:0] rresp; // Read response code
    logic [31:0] rdata; // Read data
  } rals_state_t;

  rals_state_t s_q;
  rals_state_t s_d;

  logic [4:0] det_s; // Synchronised detector levels
  logic up_s; // Loop-up code present
  logic down_s; // Loop-down code present
  logic ais_s; // All-ones alarm
  logic los_s; // Signal lost
  logic lock_s; // Pattern lock
  logic pres_a; // Level fed to first persistence timer
  logic pres_b; // Level fed to loop-down timer
  logic held_a; // First timer expired
  logic held_b; // Loop-down timer expired
  logic [3:0] stat; // Live status word
  logic [3:0] evt; // Change events this cycle
  rals_st_t mode_st; // Family state the mode bits ask for

  // ---------------------------------------------------------------
  // Input synchronisation and persistence timers
  // ---------------------------------------------------------------
  // Detectors run on the recovered clock, so every level is resynchronised
  rals_sync #(
    .W(5)
  ) u_sync (
    .i_clk_sys(i_clk_sys),
    .i_nrst(i_nrst),
    .i_async({i_loop_up_seen, i_loop_down_seen, i_all_ones_det,
              i_signal_lost_det, i_pattern_lock_det}),
    .o_sync(det_s)
  );

  assign up_s = det_s[4];
  assign down_s = det_s[3];
  assign ais_s = det_s[2];
  assign los_s = det_s[1];
  assign lock_s = det_s[0];

  // Timer feeds: manual watches either code, auto-arm only loop-up
  always_comb
  begin
    case (s_q.st)
      RALS_ST_MANUAL: pres_a = up_s | down_s;
      RALS_ST_AUTO_UP: pres_a = up_s;
      default: pres_a = 1'b0;
    endcase
    pres_b = (s_q.st == RALS_ST_AUTO_LOOP) & down_s;
  end

  rals_persist u_hold_a (
    .i_clk_sys(i_clk_sys),
    .i_nrst(i_nrst),
    .i_hold_cyc(HOLD_CYC),
    .i_present(pres_a),
    .o_held(held_a)
  );

  rals_persist u_hold_b (
    .i_clk_sys(i_clk_sys),
    .i_nrst(i_nrst),
    .i_hold_cyc(HOLD_CYC),
    .i_present(pres_b),
    .o_held(held_b)
  );

  // ---------------------------------------------------------------
  // Status and events
  // ---------------------------------------------------------------
  // Live values; reads sample these and never touch them
  assign stat = {s_q.flag, ais_s, los_s, lock_s};

  // Loop events suppressed while detection is off
  assign evt = (stat ^ s_q.prev) & {s_q.st != RALS_ST_OFF, 3'h7};

  // Family of the requested mode
  always_comb
  begin
    if (s_q.mode == RALS_MODE_OFF)
    begin
      mode_st = RALS_ST_OFF;
    end
    else if (s_q.mode == RALS_MODE_AUTO)
    begin
      mode_st = RALS_ST_AUTO_UP;
    end
    else
    begin
      mode_st = RALS_ST_MANUAL;
    end
  end

  // ---------------------------------------------------------------
  // Next state: controller, events and bus slave
  // ---------------------------------------------------------------
  always_comb
  begin
    logic aw_now;
    logic w_now;
    logic [RALS_AW-1:0] wa;
    logic [7:0] wd;
    logic wl;
    logic [3:0] clr;
    aw_now = 1'b0;
    w_now = 1'b0;
    wa = '0;
    wd = '0;
    wl = 1'b0;
    clr = '0;
    s_d = s_q;

    // Loop-code controller
    case (s_q.st)
      RALS_ST_OFF:
      begin
        s_d.flag = 1'b0;
        s_d.rlb = 1'b0;
        s_d.st = mode_st;
      end
      RALS_ST_MANUAL:
      begin
        if (mode_st != RALS_ST_MANUAL)
        begin
          // Leaving manual: auto entry starts from a cleared flag
          s_d.st = mode_st;
          s_d.flag = 1'b0;
        end
        else
        begin
          s_d.flag = held_a;
        end
      end
      RALS_ST_AUTO_UP:
      begin
        if (mode_st != RALS_ST_AUTO_UP)
        begin
          s_d.st = mode_st;
        end
        else if (held_a && up_s)
        begin
          // Timer may still hold a manual-mode loop-down count on entry,
          // so arming also needs loop-up present right now
          // Arm loopback and flag together, then watch loop-down
          s_d.st = RALS_ST_AUTO_LOOP;
          s_d.flag = 1'b1;
          s_d.rlb = 1'b1;
        end
        else
        begin
          s_d.flag = 1'b0;
        end
      end
      RALS_ST_AUTO_LOOP:
      begin
        if (mode_st != RALS_ST_AUTO_UP)
        begin
          // Mode changed away: drop loopback rather than leave it stuck
          s_d.st = mode_st;
          s_d.flag = 1'b0;
          s_d.rlb = 1'b0;
        end
        else if (held_b)
        begin
          s_d.st = RALS_ST_AUTO_UP;
          s_d.flag = 1'b0;
          s_d.rlb = 1'b0;
        end
        else
        begin
          s_d.flag = 1'b1;
        end
      end
      default:
      begin
        s_d.st = RALS_ST_OFF;
        s_d.flag = 1'b0;
        s_d.rlb = 1'b0;
      end
    endcase

    // Change detection history
    s_d.prev = stat;

    // Write channel: address and data accepted in either order
    if (s_axi_awvalid && s_axi_awready)
    begin
      s_d.aw_got = 1'b1;
      s_d.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      s_d.w_got = 1'b1;
      s_d.wdata = s_axi_wdata[7:0];
      s_d.wlane = s_axi_wstrb[0];
    end
    aw_now = s_d.aw_got;
    w_now = s_d.w_got;
    wa = s_d.awaddr;
    wd = s_d.wdata;
    wl = s_d.wlane;

    // Perform the write once both halves are in
    if (aw_now && w_now && !s_q.bvalid)
    begin
      s_d.aw_got = 1'b0;
      s_d.w_got = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = RALS_RESP_OKAY;
      case (wa)
        RALS_OFF_STATUS: ; // Read-only, write ignored
        RALS_OFF_IRQ_EN:
        begin
          if (wl)
          begin
            s_d.en = wd[3:0];
          end
        end
        RALS_OFF_MODE:
        begin
          if (wl)
          begin
            s_d.mode = wd[1:0];
          end
        end
        RALS_OFF_IRQ_STS:
        begin
          if (wl)
          begin
            clr = wd[3:0];
          end
        end
        default: s_d.bresp = RALS_RESP_SLVERR;
      endcase
    end
    if (s_q.bvalid && s_axi_bready)
    begin
      s_d.bvalid = 1'b0;
    end

    // Sticky events: a set in the clearing cycle wins
    s_d.sts = (s_q.sts & ~clr) | evt;

    // Read channel: side-effect free
    if (s_axi_arvalid && s_axi_arready)
    begin
      s_d.rvalid = 1'b1;
      s_d.rresp = RALS_RESP_OKAY;
      case (s_axi_araddr)
        RALS_OFF_STATUS: s_d.rdata = {28'h0, stat};
        RALS_OFF_IRQ_EN: s_d.rdata = {28'h0, s_q.en};
        RALS_OFF_MODE: s_d.rdata = {30'h0, s_q.mode};
        RALS_OFF_IRQ_STS: s_d.rdata = {28'h0, s_q.sts};
        default:
        begin
          s_d.rdata = 32'h0;
          s_d.rresp = RALS_RESP_SLVERR;
        end
      endcase
    end
    else if (s_q.rvalid && s_axi_rready)
    begin
      s_d.rvalid = 1'b0;
    end
  end

  // Registers with synchronous reset; all fields reset to zero
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_nrst)
    begin
      s_q <= '0;
      s_q.en <= RALS_RST_IRQ_EN;
      s_q.mode <= RALS_RST_MODE;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign o_loop_code_flag = s_q.flag;
  assign o_remote_loopback = s_q.rlb;
  assign o_irq = |(s_q.sts & s_q.en);
  assign s_axi_awready = !s_q.aw_got && !s_q.bvalid;
  assign s_axi_wready = !s_q.w_got && !s_q.bvalid;
  assign s_axi_bvalid = s_q.bvalid;
  assign s_axi_bresp = s_q.bresp;
  assign s_axi_arready = !s_q.rvalid;
  assign s_axi_rvalid = s_q.rvalid;
  assign s_axi_rresp = s_q.rresp;
  assign s_axi_rdata = s_q.rdata;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_nrst);

  a_man_flag_rise: assert property (
    $rose(s_q.flag) && s_q.st == RALS_ST_MANUAL |-> $past(held_a)
  ) else $error("manual flag rose without expired timer");

  a_man_flag_drop: assert property (
    s_q.st == RALS_ST_MANUAL && !pres_a ##1 s_q.st == RALS_ST_MANUAL |=> !s_q.flag
  ) else $error("manual flag did not drop after code loss");

  a_lc_event: assert property (
    $changed(s_q.flag) && s_q.st != RALS_ST_OFF |=> s_q.sts[RALS_BIT_LC]
  ) else $error("loop-code flag change not recorded");

  a_auto_entry: assert property (
    s_q.st == RALS_ST_MANUAL && s_q.mode == RALS_MODE_AUTO
    |=> s_q.st == RALS_ST_AUTO_UP && !s_q.flag
  ) else $error("auto entry did not clear flag");

  a_auto_arm: assert property (
    s_q.st == RALS_ST_AUTO_UP && held_a && up_s && s_q.mode == RALS_MODE_AUTO
    |=> s_q.st == RALS_ST_AUTO_LOOP && s_q.flag && s_q.rlb
  ) else $error("loopback not armed with flag");

  a_auto_hold: assert property (
    s_q.st == RALS_ST_AUTO_LOOP |-> s_q.flag && s_q.rlb
  ) else $error("flag low while loopback active");

  a_auto_release: assert property (
    s_q.st == RALS_ST_AUTO_LOOP && held_b && s_q.mode == RALS_MODE_AUTO
    |=> !s_q.flag && !s_q.rlb ##1 s_q.sts[RALS_BIT_LC]
  ) else $error("loopback release incomplete");

  a_ais_event: assert property (
    $changed(ais_s) |=> s_q.sts[RALS_BIT_AIS] && s_q.prev[RALS_BIT_AIS] == $past(ais_s)
  ) else $error("alarm change not recorded");

  a_los_event: assert property (
    $changed(los_s) |=> s_q.sts[RALS_BIT_LOS]
  ) else $error("signal lost change not recorded");

  a_lock_event: assert property (
    $changed(lock_s) |=> s_q.sts[RALS_BIT_LOCK]
  ) else $error("pattern lock change not recorded");

  a_irq_masked: assert property (
    (s_q.en == 4'h0) |-> !o_irq
  ) else $error("interrupt with all enables clear");

  a_off_quiet: assert property (
    s_q.st == RALS_ST_OFF ##1 s_q.st == RALS_ST_OFF |-> !s_q.flag && !evt[RALS_BIT_LC]
  ) else $error("loop-code activity while off");

  c_auto_arm: cover property (s_q.st == RALS_ST_AUTO_UP ##1 s_q.st == RALS_ST_AUTO_LOOP);
  c_auto_release: cover property (s_q.st == RALS_ST_AUTO_LOOP ##1 s_q.st == RALS_ST_AUTO_UP);
  c_man_flag: cover property (s_q.st == RALS_ST_MANUAL && $rose(s_q.flag));
  c_irq: cover property ($rose(o_irq));

endmodule
`default_nettype wire

// ===== rals_net_model.sv
// Model of the remote network equipment that sends loop codes on the line
`default_nettype none
module rals_net_model
(
  input wire logic i_clk_sys,
  input wire logic [1:0] i_code, // 0 idle, 1 loop-up, 2 loop-down
  output var logic o_loop_up,
  output var logic o_loop_down
);
  timeunit 1ns;
  timeprecision 100ps;
  // ---------------------------------------------------------------
  // Line code source
  // ---------------------------------------------------------------
  // Codes change only on a clock edge, the way framed line data would,
  // and the two codes are never sent at once
  always_ff @(posedge i_clk_sys)
  begin
    o_loop_up <= (i_code == 2'h1);
    o_loop_down <= (i_code == 2'h2);
  end
endmodule
`default_nettype wire

// ===== rx_alarm_loopcode_status_bench.sv
// Self-checking bench for the receive alarm and loop-code status block
`default_nettype none
module rx_alarm_loopcode_status_bench;
  timeunit 1ns;
  timeprecision 100ps;
  import rals_pkg::*;
  // ---------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------
  localparam int HN = 20; // Shortened hold time keeps the run brief
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [1:0] code = 2'h0; // Requested network code
  logic [2:0] alm = 3'h0; // Detector levels: all-ones, lost, lock
  logic up, dn, flag, lpbk, irq;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata, expv;
  int error_cnt = 0;
  int total_checks = 0;
  int cyc = 0;

  rals_net_model net (.i_clk_sys(clk), .i_code(code), .o_loop_up(up), .o_loop_down(dn));

  rals_top #(.HOLD_CYC(32'(HN))) uut (
    .i_clk_sys(clk), .i_nrst(nrst), .i_loop_up_seen(up), .i_loop_down_seen(dn),
    .i_all_ones_det(alm[2]), .i_signal_lost_det(alm[1]), .i_pattern_lock_det(alm[0]),
    .o_loop_code_flag(flag), .o_remote_loopback(lpbk), .o_irq(irq),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready));

  // ---------------------------------------------------------------
  // Clock, watchdog and closing report
  // ---------------------------------------------------------------
  initial
  begin
    forever #5 clk = ~clk;
  end

  // Whole run needs about 450 cycles; the ceiling leaves ample margin
  always @(posedge clk)
  begin
    cyc = cyc + 1;
    if (cyc == 6000)
    begin
      error_cnt = error_cnt + 1;
      complete_run();
    end
  end

  task automatic complete_run();
    begin
      $display("Checks %0d, mismatches %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0)
        $display("Testbench passed");
      else
        $display("Testbench failed");
      $finish;
    end
  endtask

  // ---------------------------------------------------------------
  // Compare and bus tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] want);
    begin
      total_checks = total_checks + 1;
      if (got !== want)
      begin
        error_cnt = error_cnt + 1;
        $display("ERROR at %0t: got %h expected %h", $time, got, want);
      end
    end
  endtask

  // Write one word; address and data are each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw_ok;
    logic w_ok;
    begin
      aw_ok = 1'b0;
      w_ok = 1'b0;
      awaddr <= a;
      wdata <= d;
      wstrb <= 4'hf;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!(aw_ok && w_ok))
      begin
        @(posedge clk);
        if (!aw_ok && awready)
        begin
          aw_ok = 1'b1;
          awvalid <= 1'b0;
        end
        if (!w_ok && wready)
        begin
          w_ok = 1'b1;
          wvalid <= 1'b0;
        end
      end
      do @(posedge clk); while (bvalid !== 1'b1);
      chk({30'h0, bresp}, {30'h0, er});
      bready <= 1'b0;
      @(posedge clk);
    end
  endtask

  // Read one word and compare data and response
  task automatic rchk(input logic [7:0] a, input logic [31:0] want, input logic [1:0] er);
    begin
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge clk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      do @(posedge clk); while (rvalid !== 1'b1);
      chk(rdata, want);
      chk({30'h0, rresp}, {30'h0, er});
      rready <= 1'b0;
      @(posedge clk);
    end
  endtask

  // Wait a bounded time for the loop-code flag to reach a level
  task automatic wait_flag(input logic v, input int lim);
    int n;
    begin
      n = 0;
      while (flag !== v && n < lim)
      begin
        @(posedge clk);
        n = n + 1;
      end
      chk({31'h0, flag}, {31'h0, v});
    end
  endtask

  // ---------------------------------------------------------------
  // Test sequence
  // ---------------------------------------------------------------
  initial
  begin
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    repeat (2) @(posedge clk);
    // Reset values, then an unmapped place
    rchk(RALS_OFF_STATUS, 32'h0, RALS_RESP_OKAY);
    rchk(RALS_OFF_IRQ_EN, 32'h0, RALS_RESP_OKAY);
    rchk(RALS_OFF_MODE, 32'h0, RALS_RESP_OKAY);
    rchk(RALS_OFF_IRQ_STS, 32'h0, RALS_RESP_OKAY);
    rchk(8'h10, 32'h0, RALS_RESP_SLVERR);
    wr(8'h14, 32'hff, RALS_RESP_SLVERR);
    $display("Test reset values done");
    // Detection off: a held code must leave the flag and events quiet
    code <= 2'h1;
    repeat (HN + 10) @(posedge clk);
    chk({31'h0, flag}, 32'h0);
    code <= 2'h0;
    repeat (6) @(posedge clk);
    rchk(RALS_OFF_IRQ_STS, 32'h0, RALS_RESP_OKAY);
    $display("Test detection off done");
    // Each live alarm: rise, mask, unmask, clear, fall
    for (int b = 0; b < 3; b++)
    begin
      expv = 32'h1 << b;
      alm <= expv[2:0];
      repeat (4) @(posedge clk);
      rchk(RALS_OFF_STATUS, expv, RALS_RESP_OKAY);
      rchk(RALS_OFF_STATUS, expv, RALS_RESP_OKAY);
      rchk(RALS_OFF_IRQ_STS, expv, RALS_RESP_OKAY);
      chk({31'h0, irq}, 32'h0);
      wr(RALS_OFF_IRQ_EN, expv, RALS_RESP_OKAY);
      chk({31'h0, irq}, 32'h1);
      wr(RALS_OFF_IRQ_STS, expv, RALS_RESP_OKAY);
      chk({31'h0, irq}, 32'h0);
      alm <= 3'h0;
      repeat (4) @(posedge clk);
      chk({31'h0, irq}, 32'h1);
      rchk(RALS_OFF_STATUS, 32'h0, RALS_RESP_OKAY);
      wr(RALS_OFF_IRQ_STS, expv, RALS_RESP_OKAY);
      wr(RALS_OFF_IRQ_EN, 32'h0, RALS_RESP_OKAY);
    end
    $display("Test live alarms done");
    // Manual modes: loop-up under 01, loop-down under 10
    wr(RALS_OFF_IRQ_EN, 32'h8, RALS_RESP_OKAY);
    for (int m = 1; m < 3; m++)
    begin
      wr(RALS_OFF_MODE, 32'(m), RALS_RESP_OKAY);
      code <= 2'(m);
      repeat (HN + 1) @(posedge clk);
      chk({31'h0, flag}, 32'h0);
      wait_flag(1'b1, 10);
      repeat (2) @(posedge clk);
      chk({31'h0, irq}, 32'h1);
      wr(RALS_OFF_IRQ_STS, 32'h8, RALS_RESP_OKAY);
      chk({31'h0, irq}, 32'h0);
      code <= 2'h0;
      wait_flag(1'b0, 6);
      repeat (2) @(posedge clk);
      chk({31'h0, irq}, 32'h1);
      wr(RALS_OFF_IRQ_STS, 32'h8, RALS_RESP_OKAY);
    end
    $display("Test manual detection done");
    // Auto entry with loop-down still flagged: clear, never arm
    code <= 2'h2;
    wait_flag(1'b1, HN + 10);
    wr(RALS_OFF_MODE, 32'h3, RALS_RESP_OKAY);
    repeat (4) @(posedge clk);
    chk({31'h0, flag}, 32'h0);
    chk({31'h0, lpbk}, 32'h0);
    wr(RALS_OFF_IRQ_STS, 32'h8, RALS_RESP_OKAY);
    // Automatic mode: loop-down ignored until looped
    wr(RALS_OFF_MODE, 32'h3, RALS_RESP_OKAY);
    chk({31'h0, flag}, 32'h0);
    code <= 2'h2;
    repeat (HN + 10) @(posedge clk);
    chk({31'h0, flag}, 32'h0);
    chk({31'h0, lpbk}, 32'h0);
    code <= 2'h1;
    wait_flag(1'b1, HN + 10);
    chk({31'h0, lpbk}, 32'h1);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, 32'h1);
    wr(RALS_OFF_IRQ_STS, 32'h8, RALS_RESP_OKAY);
    code <= 2'h0;
    repeat (HN + 10) @(posedge clk);
    chk({31'h0, flag}, 32'h1);
    // A short loop-down burst must not release the loop
    code <= 2'h2;
    repeat (HN / 2) @(posedge clk);
    code <= 2'h0;
    repeat (10) @(posedge clk);
    chk({31'h0, lpbk}, 32'h1);
    code <= 2'h2;
    wait_flag(1'b0, HN + 10);
    chk({31'h0, lpbk}, 32'h0);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, 32'h1);
    rchk(RALS_OFF_IRQ_STS, 32'h8, RALS_RESP_OKAY);
    code <= 2'h0;
    $display("Test automatic detection done");
    complete_run();
  end
endmodule
`default_nettype wire
